// ===== perec_defines.svh
// constants of the protection event recorder: sizes, codes, reset values
// assumes inclusion by every file that needs a figure of this block
`ifndef PEREC_DEFINES_SVH
`define PEREC_DEFINES_SVH
`define PEREC_EVT_DEPTH 300
`define PEREC_EVT_AW 9
`define PEREC_EVT_KEEP 50
`define PEREC_SEQ_W 16
`define PEREC_CNT_W 16
`define PEREC_TS_W 32
`define PEREC_ITEM_W 8
`define PEREC_VAL_W 16
`define PEREC_NPICK 8
`define PEREC_START_DEPTH 5
`define PEREC_START_AW 3
`define PEREC_MEAS_W 16
`define PEREC_PCT_W 8
`define PEREC_TCH 10
`define PEREC_SEL_W 8
`define PEREC_SEL_NONE 8'h00
`define PEREC_MIN_US 60000000
`define PEREC_CLK_MHZ 10
`define PEREC_MIN_CYC (`PEREC_MIN_US * `PEREC_CLK_MHZ)
`define PEREC_MINCNT_W 30
`define PEREC_TICK_W 6
`define PEREC_RES60 6'h3C
`define PEREC_RES30 6'h1E
`define PEREC_RES15 6'h0F
`define PEREC_RES10 6'h0A
`define PEREC_RES5 6'h05
`define PEREC_RES1 6'h01
`define PEREC_RISE 16'h0001
`define PEREC_FALL 16'h0100
`define PEREC_SPEED_ONE 2'h1
`define PEREC_SPEED_TWO 2'h2
`define PEREC_ITEM_PICK 8'h01
`define PEREC_ITEM_CNT 8'h02
`define PEREC_ITEM_STATE 8'h03
`endif

// ===== perec_pkg.sv
// types of the protection event recorder
// assumes perec_defines.svh is found on the include path
`include "perec_defines.svh"
package perec_pkg;
  typedef struct packed {
    logic [`PEREC_SEQ_W-1:0] seq;
    logic [`PEREC_CNT_W-1:0] fault_no;
    logic [`PEREC_CNT_W-1:0] grid_no;
    logic [`PEREC_TS_W-1:0] stamp;
    logic [`PEREC_ITEM_W-1:0] item;
    logic [`PEREC_VAL_W-1:0] value;
  } perec_event_t;
  typedef struct packed {
    logic [`PEREC_MEAS_W-1:0] peak_l1;
    logic [`PEREC_MEAS_W-1:0] peak_l2;
    logic [`PEREC_MEAS_W-1:0] peak_l3;
    logic [`PEREC_MEAS_W-1:0] ground_peak_rms;
    logic [`PEREC_MEAS_W-1:0] unbalance_max;
    logic [`PEREC_MEAS_W-1:0] avg_at_run;
    logic [1:0] speed;
    logic [`PEREC_TS_W-1:0] start_to_threshold_time;
    logic [`PEREC_TS_W-1:0] start_to_run_time;
    logic [`PEREC_PCT_W-1:0] thermal_capacity_used;
    logic success;
    logic [`PEREC_TS_W-1:0] stamp;
  } perec_start_t;
  typedef struct packed {
    logic [`PEREC_MEAS_W-1:0] l1;
    logic [`PEREC_MEAS_W-1:0] l2;
    logic [`PEREC_MEAS_W-1:0] l3;
    logic [`PEREC_MEAS_W-1:0] ground;
    logic [`PEREC_MEAS_W-1:0] unbalance;
    logic [`PEREC_MEAS_W-1:0] avg;
    logic [`PEREC_PCT_W-1:0] thermal;
  } perec_meas_t;
  typedef enum logic [2:0] {
    PEREC_IDLE = 3'h1,
    PEREC_START = 3'h2,
    PEREC_RUN = 3'h4
  } perec_mstate_t;
  typedef enum logic [2:0] {
    PEREC_R60 = 3'h0,
    PEREC_R30 = 3'h1,
    PEREC_R15 = 3'h2,
    PEREC_R10 = 3'h3,
    PEREC_R5 = 3'h4,
    PEREC_R1 = 3'h5
  } perec_res_t;
endpackage

// ===== perec_recorder.sv
// protection event recorder: event log, trend sample timing, motor start summaries
// assumes synchronous inputs from protection logic and a readout tool on clk_i
// Notes on behaviour
// - event store holds up to 300 entries
// - newest 50 events kept in power-fail-safe storage
// - entry has sequence, fault number, grid fault number, stamp, item, value
// - fault counter advances on each general pickup rising edge
// - grid fault counter advances likewise, except during auto-reclose
// - binary change logged as 0->1 or 1->0 code
// - counter increment logged as old and new value pair
// - multi-valued state change logged as old and new pair
// - trend interval selectable 60, 30, 15, 10, 5 or 1 minutes
// - ten trend channel selectors, each default unassigned
// - five start records; a sixth start overwrites the oldest
// - start records kept in power-fail-safe storage
// - summary holds peak RMS per phase, ground, unbalance, average at run
// - summary records nominal speed as 1 or 2
// - summary holds time from start until current below threshold
// - summary holds time to run, or until trip if incomplete
// - summary stores thermal capacity used as percent
// - success flag is 1 for successful start, else 0
// - delete one selected or all start records on command
// - start record holds no protection settings
// - general pickup is the OR of all pickups
`timescale 1ns/1ps
`include "perec_defines.svh"
module perec_recorder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`PEREC_NPICK-1:0] pickup_i,
  input wire logic auto_reclose_sequence_i,
  input wire logic [`PEREC_TS_W-1:0] time_stamp_i,
  input wire logic [`PEREC_ITEM_W-1:0] state_item_i,
  input wire logic [`PEREC_VAL_W/2-1:0] state_value_i,
  input wire logic [2:0] trend_resolution_i,
  input wire logic [`PEREC_TCH*`PEREC_SEL_W-1:0] trend_channel_select_i,
  input wire logic trend_select_we_i,
  input wire perec_pkg::perec_meas_t meas_i,
  input wire logic motor_start_i,
  input wire logic motor_running_i,
  input wire logic trip_i,
  input wire logic below_threshold_i,
  input wire logic speed_two_i,
  input wire logic [`PEREC_EVT_AW-1:0] evt_rd_idx_i,
  input wire logic [`PEREC_START_AW-1:0] start_sel_i,
  input wire logic start_del_one_i,
  input wire logic start_del_all_i,
  output perec_pkg::perec_event_t evt_rd_o,
  output logic [`PEREC_EVT_AW-1:0] evt_count_o,
  output logic [`PEREC_EVT_AW-1:0] evt_newest_o,
  output logic [`PEREC_CNT_W-1:0] fault_no_o,
  output logic [`PEREC_CNT_W-1:0] grid_no_o,
  output logic [`PEREC_TCH*`PEREC_SEL_W-1:0] trend_sel_o,
  output logic trend_sample_o,
  output perec_pkg::perec_start_t start_rd_o,
  output logic [`PEREC_START_DEPTH-1:0] start_valid_o,
  output logic [`PEREC_START_AW-1:0] start_newest_o
);
  wire gen_pick = |pickup_i;
  logic pick_q;
  logic [`PEREC_ITEM_W-1:0] st_item_q;
  logic [`PEREC_VAL_W/2-1:0] st_val_q;
  logic [`PEREC_CNT_W-1:0] fault_q;
  logic [`PEREC_CNT_W-1:0] grid_q;
  wire pick_rise = gen_pick & ~pick_q;
  wire pick_fall = ~gen_pick & pick_q;
  wire state_chg = (state_item_i == st_item_q) && (state_value_i != st_val_q);
  wire grid_inc = pick_rise & ~auto_reclose_sequence_i;
  wire [`PEREC_CNT_W-1:0] fault_d = fault_q + `PEREC_CNT_W'(pick_rise);
  wire [`PEREC_CNT_W-1:0] grid_d = grid_q + `PEREC_CNT_W'(grid_inc);
  // event priority: pickup edge, counter step, state change; one event a cycle
  wire [`PEREC_VAL_W-1:0] pick_code = pick_rise ? `PEREC_RISE : `PEREC_FALL;
  // the pair is logged a cycle after the step, so old is the current count less one
  wire [`PEREC_VAL_W-1:0] cnt_code = {fault_q[7:0] - 8'h01, fault_q[7:0]};
  wire [`PEREC_VAL_W-1:0] st_code = {st_val_q, state_value_i};
  logic cnt_pend_q;
  wire log_pick = pick_rise | pick_fall;
  wire log_cnt = cnt_pend_q & ~log_pick;
  wire log_st = state_chg & ~log_pick & ~log_cnt;
  wire log_any = log_pick | log_cnt | log_st;
  wire [`PEREC_ITEM_W-1:0] ev_item = log_pick ? `PEREC_ITEM_PICK :
                                     log_cnt ? `PEREC_ITEM_CNT : state_item_i;
  wire [`PEREC_VAL_W-1:0] ev_val = log_pick ? pick_code :
                                   log_cnt ? cnt_code : st_code;
  // whole store is the retained array, so the newest 50 survive
  perec_pkg::perec_event_t evt_mem [`PEREC_EVT_DEPTH];
  logic [`PEREC_EVT_AW-1:0] wr_q;
  logic [`PEREC_EVT_AW-1:0] cnt_q;
  logic [`PEREC_SEQ_W-1:0] seq_q;
  wire wr_wrap = (wr_q == `PEREC_EVT_AW'(`PEREC_EVT_DEPTH - 1));
  wire [`PEREC_EVT_AW-1:0] wr_d = wr_wrap ? '0 : wr_q + `PEREC_EVT_AW'(1);
  wire evt_full = (cnt_q == `PEREC_EVT_AW'(`PEREC_EVT_DEPTH));
  perec_pkg::perec_event_t ev_new;
  assign ev_new = '{seq: seq_q, fault_no: fault_d, grid_no: grid_d,
                    stamp: time_stamp_i, item: ev_item, value: ev_val};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pick_q <= 1'b0;
      fault_q <= '0;
      grid_q <= '0;
      st_item_q <= '0;
      st_val_q <= '0;
      cnt_pend_q <= 1'b0;
      wr_q <= '0;
      cnt_q <= '0;
      seq_q <= '0;
    end else begin
      pick_q <= gen_pick;
      fault_q <= fault_d;
      grid_q <= grid_d;
      st_item_q <= state_item_i;
      st_val_q <= state_value_i;
      cnt_pend_q <= pick_rise | (cnt_pend_q & ~log_cnt);
      if (log_any) begin
        wr_q <= wr_d;
        seq_q <= seq_q + `PEREC_SEQ_W'(1);
        if (!evt_full) cnt_q <= cnt_q + `PEREC_EVT_AW'(1);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (log_any) evt_mem[wr_q] <= ev_new;
    evt_rd_o <= evt_mem[evt_rd_idx_i];
  end
  assign evt_count_o = cnt_q;
  assign evt_newest_o = wr_q;
  assign fault_no_o = fault_q;
  assign grid_no_o = grid_q;
  perec_pkg::perec_res_t res;
  assign res = perec_pkg::perec_res_t'(trend_resolution_i);
  wire [`PEREC_TICK_W-1:0] res_min =
    (res == perec_pkg::PEREC_R60) ? `PEREC_RES60 :
    (res == perec_pkg::PEREC_R30) ? `PEREC_RES30 :
    (res == perec_pkg::PEREC_R15) ? `PEREC_RES15 :
    (res == perec_pkg::PEREC_R10) ? `PEREC_RES10 :
    (res == perec_pkg::PEREC_R5) ? `PEREC_RES5 : `PEREC_RES1;
  logic [`PEREC_MINCNT_W-1:0] cyc_q;
  logic [`PEREC_TICK_W-1:0] min_q;
  wire min_tick = (cyc_q == `PEREC_MINCNT_W'(`PEREC_MIN_CYC - 1));
  wire min_done = min_tick && (min_q >= res_min - 6'h01);
  logic [`PEREC_TCH*`PEREC_SEL_W-1:0] sel_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= '0;
      min_q <= '0;
      trend_sample_o <= 1'b0;
      sel_q <= {`PEREC_TCH{`PEREC_SEL_NONE}};
    end else begin
      cyc_q <= min_tick ? '0 : cyc_q + `PEREC_MINCNT_W'(1);
      if (min_tick) min_q <= min_done ? '0 : min_q + 6'h01;
      trend_sample_o <= min_done;
      if (trend_select_we_i) sel_q <= trend_channel_select_i;
    end
  end
  assign trend_sel_o = sel_q;
  // motor start summary
  perec_pkg::perec_mstate_t ms_q;
  perec_pkg::perec_start_t cur_q;
  logic thr_seen_q;
  perec_pkg::perec_start_t st_mem [`PEREC_START_DEPTH];
  logic [`PEREC_START_AW-1:0] swr_q;
  logic [`PEREC_START_DEPTH-1:0] svalid_q;
  wire in_start = (ms_q == perec_pkg::PEREC_START);
  wire start_end_ok = in_start & motor_running_i;
  wire start_end_bad = in_start & trip_i & ~motor_running_i;
  wire start_close = start_end_ok | start_end_bad;
  wire swr_wrap = (swr_q == `PEREC_START_AW'(`PEREC_START_DEPTH - 1));
  wire [`PEREC_MEAS_W-1:0] l1 = meas_i.l1;
  perec_pkg::perec_start_t closed;
  always_comb begin
    closed = cur_q;
    // time to run or to trip
    closed.start_to_run_time = time_stamp_i - cur_q.stamp;
    closed.success = start_end_ok;
    closed.avg_at_run = meas_i.avg;
    closed.thermal_capacity_used = meas_i.thermal - cur_q.thermal_capacity_used;
    if (!thr_seen_q) closed.start_to_threshold_time = time_stamp_i - cur_q.stamp;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_q <= perec_pkg::PEREC_IDLE;
      cur_q <= '0;
      thr_seen_q <= 1'b0;
      swr_q <= '0;
      svalid_q <= '0;
    end else begin
      case (ms_q)
        perec_pkg::PEREC_IDLE: begin
          if (motor_start_i) begin
            ms_q <= perec_pkg::PEREC_START;
            thr_seen_q <= 1'b0;
            cur_q <= '0;
            cur_q.stamp <= time_stamp_i;
            cur_q.speed <= speed_two_i ? `PEREC_SPEED_TWO : `PEREC_SPEED_ONE;
            cur_q.thermal_capacity_used <= meas_i.thermal;
          end
        end
        perec_pkg::PEREC_START: begin
          if (l1 > cur_q.peak_l1) cur_q.peak_l1 <= l1;
          if (meas_i.l2 > cur_q.peak_l2) cur_q.peak_l2 <= meas_i.l2;
          if (meas_i.l3 > cur_q.peak_l3) cur_q.peak_l3 <= meas_i.l3;
          if (meas_i.ground > cur_q.ground_peak_rms) cur_q.ground_peak_rms <= meas_i.ground;
          if (meas_i.unbalance > cur_q.unbalance_max) cur_q.unbalance_max <= meas_i.unbalance;
          if (below_threshold_i && !thr_seen_q) begin
            thr_seen_q <= 1'b1;
            cur_q.start_to_threshold_time <= time_stamp_i - cur_q.stamp;
          end
          if (start_close) ms_q <= start_end_ok ? perec_pkg::PEREC_RUN : perec_pkg::PEREC_IDLE;
        end
        perec_pkg::PEREC_RUN: begin
          if (!motor_running_i) ms_q <= perec_pkg::PEREC_IDLE;
        end
        default: ms_q <= perec_pkg::PEREC_IDLE;
      endcase
      // delete one or all; a closing start wins for its own slot
      if (start_del_all_i) svalid_q <= '0;
      else if (start_del_one_i) svalid_q[start_sel_i] <= 1'b0;
      if (start_close) begin
        svalid_q[swr_q] <= 1'b1;
        swr_q <= swr_wrap ? '0 : swr_q + `PEREC_START_AW'(1);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (start_close) st_mem[swr_q] <= closed;
    start_rd_o <= st_mem[start_sel_i];
  end
  assign start_valid_o = svalid_q;
  assign start_newest_o = swr_q;
  // checks
  property p_fault_step;
    @(posedge clk_i) disable iff (!rst_n_i)
    pick_rise |=> fault_q == $past(fault_q) + `PEREC_CNT_W'(1);
  endproperty
  a_fault_step: assert property (p_fault_step) else $error("fault count not stepped");
  property p_grid_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (pick_rise && auto_reclose_sequence_i) |=> $stable(grid_q);
  endproperty
  a_grid_hold: assert property (p_grid_hold) else $error("grid moved in reclose");
  // a pickup edge in the next cycle may legally hold the counter event back
  property p_cnt_logged;
    @(posedge clk_i) disable iff (!rst_n_i)
    pick_rise ##1 !log_pick |-> log_cnt;
  endproperty
  a_cnt_logged: assert property (p_cnt_logged) else $error("counter event not logged");
  property p_seq;
    @(posedge clk_i) disable iff (!rst_n_i)
    log_any |=> seq_q == $past(seq_q) + `PEREC_SEQ_W'(1);
  endproperty
  a_seq: assert property (p_seq) else $error("sequence not advanced");
  property p_cap;
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= `PEREC_EVT_AW'(`PEREC_EVT_DEPTH) && wr_q < `PEREC_EVT_AW'(`PEREC_EVT_DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("event store beyond capacity");
  property p_pick_code;
    @(posedge clk_i) disable iff (!rst_n_i)
    pick_rise |-> ev_val == `PEREC_RISE && log_any;
  endproperty
  a_pick_code: assert property (p_pick_code) else $error("rise code wrong");
  property p_fall_code;
    @(posedge clk_i) disable iff (!rst_n_i)
    pick_fall |-> ev_val == `PEREC_FALL && ev_item == `PEREC_ITEM_PICK && log_any;
  endproperty
  a_fall_code: assert property (p_fall_code) else $error("fall code wrong");
  property p_sample_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
    trend_sample_o |=> !trend_sample_o;
  endproperty
  a_sample_pulse: assert property (p_sample_pulse) else $error("sample pulse held");
  property p_thr_order;
    @(posedge clk_i) disable iff (!rst_n_i)
    start_close |-> closed.start_to_threshold_time <= closed.start_to_run_time;
  endproperty
  a_thr_order: assert property (p_thr_order) else $error("threshold after run");
  property p_success;
    @(posedge clk_i) disable iff (!rst_n_i)
    start_close |-> closed.success == motor_running_i;
  endproperty
  a_success: assert property (p_success) else $error("success flag wrong");
  property p_start_slot;
    @(posedge clk_i) disable iff (!rst_n_i)
    start_close |=> svalid_q[$past(swr_q)] && start_valid_o != '0;
  endproperty
  a_start_slot: assert property (p_start_slot) else $error("start slot not filled");
  property p_del_all;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start_del_all_i && !start_close) |=> svalid_q == '0;
  endproperty
  a_del_all: assert property (p_del_all) else $error("delete all failed");
  property p_speed;
    @(posedge clk_i) disable iff (!rst_n_i)
    in_start |-> cur_q.speed == `PEREC_SPEED_ONE || cur_q.speed == `PEREC_SPEED_TWO;
  endproperty
  a_speed: assert property (p_speed) else $error("speed code out of range");
  c_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i) log_any && evt_full);
  c_ok: cover property (@(posedge clk_i) disable iff (!rst_n_i) start_end_ok);
  c_bad: cover property (@(posedge clk_i) disable iff (!rst_n_i) start_end_bad);
  c_sample: cover property (@(posedge clk_i) disable iff (!rst_n_i) trend_sample_o);
endmodule

// ===== perec_prot_model.sv
// partner model: the time source of the protection logic
// assumes one clock shared with the recorder and the same reset
`timescale 1ns/1ps
`include "perec_defines.svh"
module perec_prot_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [`PEREC_TS_W-1:0] time_stamp_o
);
  // free running, so a difference of two stamps is a count of clock cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_stamp_o <= 32'h0;
    end else begin
      time_stamp_o <= time_stamp_o + 32'h1;
    end
  end
endmodule

// ===== perec_recorder_tb.sv
// self-checking bench of the protection event recorder
// assumes perec_pkg and perec_prot_model are compiled before this file
`timescale 1ns/1ps
`include "perec_defines.svh"
module perec_recorder_tb;
  logic clk = 1'h0, rst_n = 1'h0, ar = 1'h0, we = 1'h0, mst = 1'h0, run = 1'h0;
  logic trip = 1'h0, thr = 1'h0, sp2 = 1'h0, d1 = 1'h0, da = 1'h0, tsmp;
  logic [7:0] pick = 8'h00, item = 8'h30, sval = 8'h05;
  logic [79:0] tsel = 80'h0, tso;
  logic [31:0] ts;
  logic [8:0] ridx = 9'h0, ecnt, enew;
  logic [2:0] ssel = 3'h0, snew, tres = 3'h5;
  logic [4:0] svld;
  logic [15:0] fno, gno;
  perec_pkg::perec_meas_t meas = '0;
  perec_pkg::perec_event_t er, evt;
  perec_pkg::perec_start_t sr, srd;
  int n_fail = 0, comparisons = 0, n_smp = 0;
  localparam logic [7:0] exp_item [7] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h02, 8'h01, 8'h30};
  localparam logic [15:0] exp_val [7] = '{16'h0001, 16'h0001, 16'h0100, 16'h0001, 16'h0102,
    16'h0100, 16'h0507};
  localparam logic [15:0] exp_fno [7] = '{16'h1, 16'h1, 16'h1, 16'h2, 16'h2, 16'h2, 16'h2};

  always #50 clk = ~clk;

  // every interval is at least a minute, far longer than this run
  always @(posedge clk) if (rst_n && tsmp !== 1'h0) n_smp++;

  perec_prot_model i_perec_prot_model (.clk_i(clk), .rst_n_i(rst_n), .time_stamp_o(ts));

  perec_recorder i_perec_recorder (
    .clk_i(clk), .rst_n_i(rst_n), .pickup_i(pick), .auto_reclose_sequence_i(ar),
    .time_stamp_i(ts), .state_item_i(item), .state_value_i(sval),
    .trend_resolution_i(tres), .trend_channel_select_i(tsel), .trend_select_we_i(we),
    .meas_i(meas), .motor_start_i(mst), .motor_running_i(run), .trip_i(trip),
    .below_threshold_i(thr), .speed_two_i(sp2), .evt_rd_idx_i(ridx), .start_sel_i(ssel),
    .start_del_one_i(d1), .start_del_all_i(da), .evt_rd_o(evt), .evt_count_o(ecnt),
    .evt_newest_o(enew), .fault_no_o(fno), .grid_no_o(gno), .trend_sel_o(tso),
    .trend_sample_o(tsmp), .start_rd_o(srd), .start_valid_o(svld), .start_newest_o(snew)
  );

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task rd_evt(input logic [8:0] idx);
    ridx = idx;
    step(2);
    er = evt;
  endtask

  // rise and fall of the pickup, spaced so the counter event never collides
  task pulse(input logic [7:0] bits, input logic a);
    ar = a;
    pick = bits;
    step(2);
    pick = 8'h00;
    step(2);
  endtask

  // one start-up closed by running or by trip, then its slot is read back
  task start(input logic s2, input logic tr, input logic [2:0] slot);
    sp2 = s2;
    meas = '0;
    meas.thermal = 8'h0A;
    meas.l1 = 16'h0100;
    mst = 1'h1;
    step(1);
    mst = 1'h0;
    meas.l1 = 16'h0300;
    meas.l2 = 16'h0250;
    meas.l3 = 16'h0280;
    meas.ground = 16'h0040;
    meas.unbalance = 16'h0012;
    meas.thermal = 8'h23;
    step(2);
    meas.l1 = 16'h0200;
    meas.avg = 16'h0222;
    thr = !tr;
    step(3);
    run = !tr;
    trip = tr;
    step(1);
    run = 1'h0;
    trip = 1'h0;
    thr = 1'h0;
    ssel = slot;
    step(2);
    sr = srd;
    check(sr.peak_l1, 16'h0300);
    check({sr.peak_l2, sr.peak_l3, sr.ground_peak_rms, sr.unbalance_max},
      64'h0250028000400012);
    if (!tr) check(sr.avg_at_run, 16'h0222);
    check(sr.speed, s2 ? `PEREC_SPEED_TWO : `PEREC_SPEED_ONE);
    check(sr.start_to_run_time, 32'h6);
    check(sr.start_to_run_time - sr.start_to_threshold_time,
      tr ? 32'h0 : 32'h3);
    check(sr.thermal_capacity_used, 8'h19);
    check(sr.success, !tr);
  endtask

  // the whole run needs about 540 cycles; this leaves wide margin
  initial begin
    #3000000;
    n_fail++;
    end_of_test;
  end

  initial begin
    step(6);
    rst_n = 1'h1;
    step(1);
    check({ecnt, fno, gno, svld}, 64'h0);
    check(tso, 80'h0);
    pulse(8'h04, 1'h0);
    check({fno, gno}, 32'h00010001);
    pulse(8'h80, 1'h1);
    check({fno, gno}, 32'h00020001);
    ar = 1'h0;
    sval = 8'h07;
    step(3);
    check({ecnt, enew}, {9'h7, 9'h7});
    for (int i = 0; i < 7; i++) begin
      rd_evt(i[8:0]);
      check({er.item, er.value}, {exp_item[i], exp_val[i]});
      check({er.fault_no, er.grid_no}, {exp_fno[i], 16'h0001});
      check(er.seq, i[15:0]);
    end
    for (int k = 0; k < 110; k++) pulse(8'h01, 1'h0);
    check({ecnt, fno, gno}, {9'h12C, 16'h0070, 16'h006F});
    check(enew, 9'h025);
    rd_evt(9'h024);
    check({er.seq, er.item, er.value}, {16'h0150, 8'h01, 16'h0100});
    rd_evt(9'h025);
    check(er.seq, 16'h0025);
    tsel = 80'h0A090807060504030201;
    we = 1'h1;
    step(1);
    we = 1'h0;
    step(1);
    check(tso, 80'h0A090807060504030201);
    for (int s = 0; s < 6; s++) start(s[0], s == 1, 3'(s % 5));
    check({svld, snew}, {5'h1F, 3'h1});
    ssel = 3'h2;
    step(1);
    d1 = 1'h1;
    step(1);
    d1 = 1'h0;
    step(1);
    check(svld, 5'h1B);
    da = 1'h1;
    step(1);
    da = 1'h0;
    step(1);
    check(svld, 5'h00);
    check(n_smp, 0);
    end_of_test;
  end
endmodule
